/* File: src/pds_config_bank.sv */
/*
 * Loop divider and tuning/sleep configuration bank.
 * Two 16-bit registers on a plain port with read data one cycle later.
 * Outputs drive the analog controls of the loop, bias, sensor, receivers and channels.
 * Assumes one clock, all inputs synchronous to it; the loop enable arrives from
 * a neighbouring register on the same clock.
 */
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module pds_config_bank
	import pds_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Loop enable from the neighbouring control register
	input wire logic loop_enable_i,
	// Loop controls
	output logic [7:0] m_ratio_o,
	output logic [4:0] n_ratio_o,
	output logic m_ratio_legal_o,
	output logic [1:0] vco_bias_tune_o,
	output logic [5:0] vco_coarse_tune_o,
	output logic loop_active_o,
	output logic loop_bypass_o,
	// Power controls
	output logic bias_sleep_o,
	output logic tsense_sleep_o,
	output logic loop_sleep_o,
	output logic clkrecv_sleep_o,
	output logic sync_reference_strobe_sleep_o,
	output logic channel_a_powerdown_o,
	output logic channel_b_powerdown_o,
	output logic channel_c_powerdown_o,
	output logic channel_d_powerdown_o
);
	logic [15:0] loop_divider_config;
	logic [15:0] tuning_and_sleep_control;
	logic [7:0] next_m_ratio;
	logic [4:0] next_n_ratio;
	logic next_m_legal;

	// Address match shared by write and read paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
		return a == idx;
	endfunction

	// Divider register; reserved bits masked so they always read zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			loop_divider_config <= LOOP_DIVIDER_CONFIG_RST;
		end else if (wr_i && hit(addr_i, LOOP_DIVIDER_CONFIG_IDX)) begin
			loop_divider_config <= wdata_i & LOOP_DIVIDER_WMASK;
		end
	end

	// Tuning and sleep register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tuning_and_sleep_control <= TUNING_AND_SLEEP_CONTROL_RST;
		end else if (wr_i && hit(addr_i, TUNING_AND_SLEEP_CONTROL_IDX)) begin
			tuning_and_sleep_control <= wdata_i & TUNING_SLEEP_WMASK;
		end
	end

	// Read data one cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			if (hit(addr_i, LOOP_DIVIDER_CONFIG_IDX)) begin
				rdata_o <= loop_divider_config;
			end else if (hit(addr_i, TUNING_AND_SLEEP_CONTROL_IDX)) begin
				rdata_o <= tuning_and_sleep_control;
			end else begin
				rdata_o <= 16'h0000;
			end
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	pds_ratio_decode u_decode (
		.m_field_i(loop_divider_config[M_MSB:M_LSB]),
		.n_field_i(loop_divider_config[N_MSB:N_LSB]),
		.m_ratio_o(next_m_ratio),
		.n_ratio_o(next_n_ratio),
		.m_legal_o(next_m_legal)
	);

	// Loop settings, registered; ratios only steer the loop while it is enabled
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			m_ratio_o <= 8'h04;
			n_ratio_o <= 5'h05;
			m_ratio_legal_o <= 1'b1;
			vco_bias_tune_o <= 2'h0;
			vco_coarse_tune_o <= 6'h00;
			loop_active_o <= 1'b0;
			loop_bypass_o <= 1'b1;
		end else begin
			m_ratio_o <= next_m_ratio;
			n_ratio_o <= next_n_ratio;
			m_ratio_legal_o <= next_m_legal;
			vco_bias_tune_o <= loop_divider_config[ITUNE_MSB:ITUNE_LSB];
			vco_coarse_tune_o <= tuning_and_sleep_control[VCO_MSB:VCO_LSB];
			// Bypassed loop ignores the dividers; sleep also stops it
			loop_active_o <= loop_enable_i &&
				!tuning_and_sleep_control[LOOP_SLEEP_BIT];
			loop_bypass_o <= !loop_enable_i;
		end
	end

	// Sleep controls follow the register one cycle after the write
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bias_sleep_o <= 1'b0;
			tsense_sleep_o <= 1'b0;
			loop_sleep_o <= 1'b1;
			clkrecv_sleep_o <= 1'b0;
			sync_reference_strobe_sleep_o <= 1'b0;
			channel_a_powerdown_o <= 1'b0;
			channel_b_powerdown_o <= 1'b0;
			channel_c_powerdown_o <= 1'b0;
			channel_d_powerdown_o <= 1'b0;
		end else begin
			bias_sleep_o <= tuning_and_sleep_control[BIAS_SLEEP_BIT];
			tsense_sleep_o <= tuning_and_sleep_control[TSENSE_SLEEP_BIT];
			loop_sleep_o <= tuning_and_sleep_control[LOOP_SLEEP_BIT];
			clkrecv_sleep_o <= tuning_and_sleep_control[CLKRECV_SLEEP_BIT];
			// Strobe receiver shares the clock receiver's sleep
			sync_reference_strobe_sleep_o <= tuning_and_sleep_control[CLKRECV_SLEEP_BIT];
			channel_a_powerdown_o <= tuning_and_sleep_control[CHAN_A_BIT];
			channel_b_powerdown_o <= tuning_and_sleep_control[CHAN_B_BIT];
			channel_c_powerdown_o <= tuning_and_sleep_control[CHAN_C_BIT];
			channel_d_powerdown_o <= tuning_and_sleep_control[CHAN_D_BIT];
		end
	end
endmodule

/* File: src/pds_pkg.sv */
/*
 * Package for the loop divider and sleep configuration bank.
 * Holds register indices, field positions, reset values and decode limits.
 * Assumes a word-addressed plain register port with 16-bit data.
 */
// Behaviour
// - With the divider mode bit clear, the feedback ratio is the low seven bits, legal 4 to 127.
// - With the mode bit set, the feedback ratio is twice the low seven bits, legal 8 to 254.
// - The reference ratio is the four-bit field plus one, from 1 up to 16.
// - The top six bits of the second register are the coarse oscillator tuning code, reset zero.
// - A set bias sleep bit holds the bias amplifier asleep.
// - A set sensor sleep bit powers off the temperature sensor.
// - A set loop sleep bit keeps the loop asleep, and it resets to one.
// - A set receiver sleep bit sleeps the clock receiver and the strobe receiver with it.
// - Bits 3 to 0 put channels A to D to sleep, one bit each.
// - After reset the divider register reads 0x0440 and the sleep register reads 0x0020.
// - The loop runs only when its enable is set; otherwise it is bypassed.
package pds_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	// Register indices, word addressed
	localparam logic [7:0] LOOP_DIVIDER_CONFIG_IDX = 8'h19;
	localparam logic [7:0] TUNING_AND_SLEEP_CONTROL_IDX = 8'h1a;
	// Reset values
	localparam logic [15:0] LOOP_DIVIDER_CONFIG_RST = 16'h0440;
	localparam logic [15:0] TUNING_AND_SLEEP_CONTROL_RST = 16'h0020;
	// Divider register fields
	localparam int M_MSB = 15;
	localparam int M_LSB = 8;
	localparam int M_MODE_BIT = 15;
	localparam int N_MSB = 7;
	localparam int N_LSB = 4;
	localparam int ITUNE_MSB = 3;
	localparam int ITUNE_LSB = 2;
	// Write mask: reserved bits 1:0 stay zero
	localparam logic [15:0] LOOP_DIVIDER_WMASK = 16'hfffc;
	// Sleep register fields
	localparam int VCO_MSB = 15;
	localparam int VCO_LSB = 10;
	localparam int BIAS_SLEEP_BIT = 7;
	localparam int TSENSE_SLEEP_BIT = 6;
	localparam int LOOP_SLEEP_BIT = 5;
	localparam int CLKRECV_SLEEP_BIT = 4;
	localparam int CHAN_A_BIT = 3;
	localparam int CHAN_B_BIT = 2;
	localparam int CHAN_C_BIT = 1;
	localparam int CHAN_D_BIT = 0;
	// Write mask: reserved bits 9:8 stay zero
	localparam logic [15:0] TUNING_SLEEP_WMASK = 16'hfcff;
	// Decode limits for the feedback ratio
	localparam logic [6:0] M_DIRECT_MIN = 7'h04;
	localparam logic [6:0] M_DOUBLE_MIN = 7'h04;
endpackage

/* File: src/pds_ratio_decode.sv */
/*
 * Combinational decode of the loop divider fields into ratios.
 * Assumes the raw fields come from registers on the same clock.
 */
`timescale 1ns/1ps
module pds_ratio_decode
	import pds_pkg::*;
(
	// Raw fields
	input wire logic [7:0] m_field_i,
	input wire logic [3:0] n_field_i,
	// Decoded ratios
	output logic [7:0] m_ratio_o,
	output logic [4:0] n_ratio_o,
	output logic m_legal_o
);
	// Feedback ratio: direct or doubled, legality per mode
	always_comb begin
		if (m_field_i[7]) begin
			m_ratio_o = {m_field_i[6:0], 1'b0};
			m_legal_o = (m_field_i[6:0] >= M_DOUBLE_MIN);
		end else begin
			m_ratio_o = {1'b0, m_field_i[6:0]};
			m_legal_o = (m_field_i[6:0] >= M_DIRECT_MIN);
		end
	end

	// Reference ratio is stored value plus one
	assign n_ratio_o = {1'b0, n_field_i} + 5'h01;
endmodule

/* File: verification/pds_config_checker.sv */
/* Assertions for the loop divider and sleep bank.
   Assumes a bind to every pds_config_bank instance. */
`timescale 1ns/1ps
module pds_config_checker
	import pds_pkg::*;
(
	// Clock, reset and register port
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	// Controls
	input wire logic loop_enable_i,
	input wire logic [7:0] m_ratio_o,
	input wire logic [4:0] n_ratio_o,
	input wire logic [5:0] vco_coarse_tune_o,
	input wire logic loop_active_o,
	input wire logic loop_bypass_o,
	input wire logic loop_sleep_o,
	input wire logic clkrecv_sleep_o,
	input wire logic sync_reference_strobe_sleep_o,
	input wire logic channel_a_powerdown_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic w19;
	logic w1a;
	// Writes reach the outputs two edges later
	assign w19 = wr_i && addr_i == LOOP_DIVIDER_CONFIG_IDX;
	assign w1a = wr_i && addr_i == TUNING_AND_SLEEP_CONTROL_IDX;
	chk_m_direct: assert property (w19 && !wdata_i[15] |-> ##2
		m_ratio_o == {1'b0, $past(wdata_i[14:8], 2)}) else $error("direct ratio wrong");
	chk_m_double: assert property (w19 && wdata_i[15] |-> ##2
		m_ratio_o == {$past(wdata_i[14:8], 2), 1'b0}) else $error("doubled ratio wrong");
	chk_n_ratio: assert property (w19 |-> ##2
		n_ratio_o == $past(wdata_i[7:4], 2) + 5'h1) else $error("reference ratio wrong");
	chk_coarse_tune: assert property (w1a |-> ##2
		vco_coarse_tune_o == $past(wdata_i[15:10], 2)) else $error("coarse tune wrong");
	chk_loop_sleep: assert property (w1a |-> ##2
		loop_sleep_o == $past(wdata_i[5], 2)) else $error("loop sleep wrong");
	chk_chan_sleep: assert property (w1a |-> ##2
		channel_a_powerdown_o == $past(wdata_i[3], 2)) else $error("channel sleep wrong");
	chk_strobe_pair: assert property (
		sync_reference_strobe_sleep_o == clkrecv_sleep_o) else $error("strobe sleep apart");
	chk_loop_bypass: assert property (!$past(rst_i) |->
		loop_bypass_o == !$past(loop_enable_i)) else $error("bypass wrong");
	chk_loop_active: assert property (loop_active_o |->
		!loop_bypass_o && !loop_sleep_o) else $error("loop active wrongly");
	chk_rsvd_read: assert property ($past(rd_i && addr_i == LOOP_DIVIDER_CONFIG_IDX) |->
		rdata_o[1:0] == 2'h0) else $error("reserved bits read set");
	cover property (w19 && wdata_i[15]);
	cover property (w1a && !wdata_i[5]);
	cover property (loop_active_o);
endmodule
bind pds_config_bank pds_config_checker u_chk (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .loop_enable_i, .m_ratio_o, .n_ratio_o, .vco_coarse_tune_o,
	.loop_active_o, .loop_bypass_o, .loop_sleep_o, .clkrecv_sleep_o,
	.sync_reference_strobe_sleep_o, .channel_a_powerdown_o);

/* File: verification/test_pds_config_bank.sv */
/* Self-checking bench for the divider and sleep bank.
   Assumes the checker is bound in beside the design. */
`timescale 1ns/1ps
module test_pds_config_bank;
	logic clk_i, rst_i, wr_i, rd_i, en, leg, act, byp;
	logic [7:0] addr_i, m, a;
	logic [15:0] wdata_i, rdata_o, r19, r1a, d;
	logic [4:0] n;
	logic [1:0] bt;
	logic [5:0] ct;
	logic [8:0] sl;
	int n_errors, tests_run, seed, lo, i;
	int cyc = 0;
	pds_config_bank DUT (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.loop_enable_i(en), .m_ratio_o(m), .n_ratio_o(n), .m_ratio_legal_o(leg),
		.vco_bias_tune_o(bt), .vco_coarse_tune_o(ct), .loop_active_o(act), .loop_bypass_o(byp),
		.bias_sleep_o(sl[7]), .tsense_sleep_o(sl[6]), .loop_sleep_o(sl[5]),
		.clkrecv_sleep_o(sl[4]), .sync_reference_strobe_sleep_o(sl[8]),
		.channel_a_powerdown_o(sl[3]), .channel_b_powerdown_o(sl[2]),
		.channel_c_powerdown_o(sl[1]), .channel_d_powerdown_o(sl[0]));
	initial begin
		clk_i = 0;
		forever #2.5 clk_i = ~clk_i;
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// One strobe cycle; returns at the edge that takes it, strobe still up
	// so a following access can replace it without a double assignment
	task acc(input logic w, input logic [7:0] ad, input logic [15:0] dd);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= ad;
		wdata_i <= dd;
		@(posedge clk_i);
	endtask
	// Drop both strobes right after the edge that took the last access
	task idle;
		wr_i <= 0;
		rd_i <= 0;
	endtask
	// Reset, then both registers and the ratios must show defaults
	task do_reset;
		rst_i <= 1;
		en <= 0;
		r19 = 16'h0440;
		r1a = 16'h0020;
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		acc(0, 8'h19, 16'h0);
		idle;
		#1 chk(rdata_o, 16'h0440);
		@(posedge clk_i);
		acc(0, 8'h1a, 16'h0);
		idle;
		#1 chk(rdata_o, 16'h0020);
		chk({m, 3'h0, n}, 16'h0405);
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			wrap_up;
		end
	end
	initial begin
		{rst_i, wr_i, rd_i, en, addr_i, wdata_i} = 28'h8000000;
		seed = 32'hf0c1e0bc;
		n_errors = 0;
		tests_run = 0;
		do_reset;
		// Random write then back-to-back readback; every eighth goes anywhere
		for (i = 0; i < 60; i++) begin
			@(posedge clk_i);
			a = ($random(seed) & 1) ? 8'h19 : 8'h1a;
			if (i % 8 == 7) a = 8'($random(seed));
			d = 16'($random(seed));
			en <= 1'($random(seed));
			acc(1, a, d);
			if (a == 8'h19) r19 = d & 16'hfffc;
			if (a == 8'h1a) r1a = d & 16'hfcff;
			acc(0, a, 16'h0);
			idle;
			#1 chk(rdata_o, a == 8'h19 ? r19 : a == 8'h1a ? r1a : 16'h0);
			@(posedge clk_i);
			#1 lo = r19[14:8];
			chk(m, 16'(r19[15] ? 2 * lo : lo));
			chk(n, r19[7:4] + 5'h1);
			chk({leg, bt, ct}, {lo >= 4, r19[3:2], r1a[15:10]});
			chk(sl, {r1a[4], r1a[7:0]});
			chk({act, byp}, {en & !r1a[5], !en});
		end
		do_reset;
		wrap_up;
	end
endmodule
